// >>> pkg/devctl_pkg.sv
// Register map, field layouts and reset values of the device control bank
package devctl_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CHAN_N = 4;
    localparam int CHAN_W = 2;
    localparam int LINK_W = 4;
    localparam int PKT_W  = 16;

    localparam logic [7:0] OFF_CHAN_SEL   = 8'h00;
    localparam logic [7:0] OFF_CHAN_DIR   = 8'h04;
    localparam logic [7:0] OFF_CHAN_LINK  = 8'h08;
    localparam logic [7:0] OFF_CHAN_ORDER = 8'h0C;
    localparam logic [7:0] OFF_CHAN_PKT   = 8'h10;
    localparam logic [7:0] OFF_EVT_TOTAL  = 8'h14;
    localparam logic [7:0] OFF_MSG_TOTAL  = 8'h18;
    localparam logic [7:0] OFF_TEXT_ENC   = 8'h1C;
    localparam logic [7:0] OFF_RESTART    = 8'h20;
    localparam logic [7:0] OFF_LAMP_MODE  = 8'h24;
    localparam logic [7:0] OFF_COMMAND    = 8'h28;
    localparam logic [7:0] OFF_STATUS     = 8'h2C;

    // Command register bit positions
    localparam int CMD_PERSIST_BEGIN  = 0;
    localparam int CMD_PERSIST_FINISH = 1;
    localparam int CMD_BULK_BEGIN     = 2;
    localparam int CMD_BULK_FINISH    = 3;
    // Status register bit positions
    localparam int ST_CONSISTENT = 0;
    localparam int ST_PERSIST    = 1;
    localparam int ST_BULK       = 2;
    localparam int ST_BULK_LOCK  = 3;

    localparam logic [31:0] RESTART_KEY      = 32'h0000_0001;
    localparam logic [3:0]  RESTART_ACK_CYC  = 4'h4;
    localparam logic [15:0] PKT_RESET        = 16'h05DC;
    localparam logic [3:0]  CHAN_DIR_RESET   = 4'h1;
    localparam logic [7:0]  EVT_TOTAL_VAL    = 8'h01;
    localparam logic        TEXT_ENC_ASCII   = 1'b1;
    localparam logic [31:0] UNMAPPED_VAL     = 32'h0000_0000;

    typedef enum logic [1:0] {
        LAMP_OFF        = 2'h0,
        LAMP_ACTIVE     = 2'h1,
        LAMP_ERROR_ONLY = 2'h2
    } lamp_mode_e;

    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_ACK  = 2'b01,
        RS_FIRE = 2'b11
    } restart_state_e;
endpackage : devctl_pkg

// >>> src/restart_sequencer.sv
// Acknowledge-then-restart sequencer for the full restart command
`timescale 1ns/1ps
`default_nettype none
module restart_sequencer (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic restart_req,
    output logic      restart_ack,
    output logic      restart_fire
);
    import devctl_pkg::*;

    restart_state_e state_r;
    restart_state_e state_nxt;
    logic [3:0]     cnt_r;
    logic [3:0]     cnt_nxt;
    logic           ack_r;
    logic           fire_r;

    // Ack goes out first, restart only after the ack window
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            RS_IDLE: begin
                if (restart_req) begin
                    state_nxt = RS_ACK;
                    cnt_nxt   = RESTART_ACK_CYC;
                end
            end
            RS_ACK: begin
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'h1) begin
                    state_nxt = RS_FIRE;
                end
            end
            RS_FIRE: begin
                state_nxt = RS_IDLE;
            end
            default: begin
                state_nxt = RS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= RS_IDLE;
            cnt_r   <= 4'h0;
            ack_r   <= 1'b0;
            fire_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            ack_r   <= (state_r == RS_IDLE) && restart_req;
            fire_r  <= (state_r == RS_ACK) && (cnt_r == 4'h1);
        end
    end

    assign restart_ack  = ack_r;
    assign restart_fire = fire_r;

    sequence ack_seen;
        restart_ack;
    endsequence

    sequence fire_after_ack;
        !restart_fire [*4] ##1 restart_fire;
    endsequence

    ack_before_fire_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        ack_seen |-> fire_after_ack)
        else $error("restart fired without ack delay");
endmodule : restart_sequencer
`default_nettype wire

// >>> src/device_control_bank.sv
// Device control and status register bank with stream channel settings
//
// Function
// - Report selected channel as transmitter or receiver
// - Hold writable link index per channel
// - Per-channel byte order orders pixel bytes
// - Transmitter packet length positive, sets packet size
// - Receiver packet length is largest accepted
// - Read-only event channel count
// - Legacy count mirrors event channel count
// - Report bootstrap text encoding read-only
// - Full restart returns register bank state to power-up
// - Acknowledge restart before restarting
// - Lamps off, active, or error-only
// - Persistence begin enters preparation state
// - Persistence finish leaves preparation state
// - Bulk begin accepts writes unchecked
// - Bulk finish checks then activates set
// - Bulk finish refreshes consistency flag
// - Read-only register set consistency flag
// - Writable channel index selects per-channel settings
`timescale 1ns/1ps
`default_nettype none
module device_control_bank (
    input  wire logic                           core_clk,
    input  wire logic                           reset_n,
    input  wire logic [devctl_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [devctl_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                           reg_write,
    input  wire logic                           reg_read,
    output logic      [devctl_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic [devctl_pkg::CHAN_N-1:0]  chan_is_receiver,
    input  wire logic                           device_error,
    input  wire logic                           status_lamp_raw,
    input  wire logic [devctl_pkg::CHAN_N*16-1:0] pixel_in,
    input  wire logic                           bulk_locked,
    output logic      [devctl_pkg::CHAN_N*16-1:0] pixel_out,
    output logic      [devctl_pkg::CHAN_N*devctl_pkg::LINK_W-1:0] stream_channel_link_index,
    output logic      [devctl_pkg::CHAN_N*devctl_pkg::PKT_W-1:0]  stream_packet_bytes,
    output logic                                status_lamp,
    output logic                                restart_ack,
    output logic                                device_restart
);
    import devctl_pkg::*;

    // Staging feeds the live settings: applied at a bulk finish whose check passes, or every cycle outside bulk while the set is consistent
    logic [CHAN_W-1:0] stream_channel_index_select_r;
    logic [CHAN_N-1:0] stream_byte_order_r;
    logic [LINK_W-1:0] link_r    [CHAN_N];
    logic [PKT_W-1:0]  pkt_r     [CHAN_N];
    logic [LINK_W-1:0] link_stg_r[CHAN_N];
    logic [PKT_W-1:0]  pkt_stg_r [CHAN_N];
    logic [CHAN_N-1:0] order_stg_r;
    lamp_mode_e        status_lamp_behaviour_r;
    logic              persist_r;
    logic              bulk_r;
    logic              register_set_consistent_flag_r;
    logic [DATA_W-1:0] rdata_r;
    logic              lamp_r;
    logic [CHAN_N*16-1:0] pix_r;
    logic [1:0]        err_sync_r;
    logic [1:0]        lamp_sync_r;
    logic [1:0]        lock_sync_r;
    logic [CHAN_N-1:0] dir_sync0_r;
    logic [CHAN_N-1:0] dir_sync1_r;
    logic              restart_fire;
    logic              soft_rst_r;

    function automatic logic [15:0] order_bytes(input logic [15:0] v, input logic big);
        order_bytes = big ? {v[7:0], v[15:8]} : v;
    endfunction : order_bytes

    function automatic logic sel_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        sel_hit = (a == off);
    endfunction : sel_hit

    wire wr_sel     = reg_write && sel_hit(reg_addr, OFF_CHAN_SEL);
    wire wr_link    = reg_write && sel_hit(reg_addr, OFF_CHAN_LINK);
    wire wr_order   = reg_write && sel_hit(reg_addr, OFF_CHAN_ORDER);
    wire wr_pkt     = reg_write && sel_hit(reg_addr, OFF_CHAN_PKT);
    wire wr_lamp    = reg_write && sel_hit(reg_addr, OFF_LAMP_MODE);
    wire wr_cmd     = reg_write && sel_hit(reg_addr, OFF_COMMAND);
    wire wr_restart = reg_write && sel_hit(reg_addr, OFF_RESTART)
                      && (reg_wdata == RESTART_KEY);
    wire lock_s     = lock_sync_r[1];
    // Commands are decoded from the write strobe only, never stored
    wire cmd_p_beg  = wr_cmd && reg_wdata[CMD_PERSIST_BEGIN];
    wire cmd_p_end  = wr_cmd && reg_wdata[CMD_PERSIST_FINISH];
    wire cmd_b_beg  = wr_cmd && reg_wdata[CMD_BULK_BEGIN] && !lock_s;
    wire cmd_b_end  = wr_cmd && reg_wdata[CMD_BULK_FINISH] && bulk_r;
    wire sel_rx     = dir_sync1_r[stream_channel_index_select_r];
    // A zero packet size is rejected outside bulk mode; also a consistency check failure
    wire pkt_ok     = (reg_wdata[PKT_W-1:0] != '0);
    wire lamp_mode_ok = (reg_wdata[1:0] != 2'h3);
    logic set_ok;
    always_comb begin
        set_ok = 1'b1;
        for (int i = 0; i < CHAN_N; i++) begin
            if (pkt_stg_r[i] == '0) begin
                set_ok = 1'b0;
            end
        end
    end
    wire lamp_nxt = (status_lamp_behaviour_r == LAMP_ACTIVE) ? lamp_sync_r[1] :
                    (status_lamp_behaviour_r == LAMP_ERROR_ONLY) ? err_sync_r[1] :
                    1'b0;
    wire rst_all_n = reset_n;

    wire [DATA_W-1:0] rd_mux =
        sel_hit(reg_addr, OFF_CHAN_SEL)   ? {30'h0, stream_channel_index_select_r} :
        sel_hit(reg_addr, OFF_CHAN_DIR)   ? {31'h0, sel_rx} :
        sel_hit(reg_addr, OFF_CHAN_LINK)  ? {28'h0, link_stg_r[stream_channel_index_select_r]} :
        sel_hit(reg_addr, OFF_CHAN_ORDER) ? {31'h0, order_stg_r[stream_channel_index_select_r]} :
        sel_hit(reg_addr, OFF_CHAN_PKT)   ? {16'h0, pkt_stg_r[stream_channel_index_select_r]} :
        sel_hit(reg_addr, OFF_EVT_TOTAL)  ? {24'h0, EVT_TOTAL_VAL} :
        sel_hit(reg_addr, OFF_MSG_TOTAL)  ? {24'h0, EVT_TOTAL_VAL} :
        sel_hit(reg_addr, OFF_TEXT_ENC)   ? {31'h0, TEXT_ENC_ASCII} :
        sel_hit(reg_addr, OFF_LAMP_MODE)  ? {30'h0, status_lamp_behaviour_r} :
        sel_hit(reg_addr, OFF_STATUS)     ? {28'h0, lock_s, bulk_r, persist_r,
                                             register_set_consistent_flag_r} :
        UNMAPPED_VAL;

    restart_sequencer u_restart (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .restart_req  (wr_restart),
        .restart_ack  (restart_ack),
        .restart_fire (restart_fire)
    );

    // Input synchronisers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            err_sync_r  <= 2'b00;
            lamp_sync_r <= 2'b00;
            lock_sync_r <= 2'b00;
            dir_sync0_r <= CHAN_DIR_RESET;
            dir_sync1_r <= CHAN_DIR_RESET;
        end else begin
            err_sync_r  <= {err_sync_r[0], device_error};
            lamp_sync_r <= {lamp_sync_r[0], status_lamp_raw};
            lock_sync_r <= {lock_sync_r[0], bulk_locked};
            dir_sync0_r <= chan_is_receiver;
            dir_sync1_r <= dir_sync0_r;
        end
    end

    // Soft restart: registered one cycle after fire, the register bank state below returns to reset on the next edge; the output registers do not
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= restart_fire;
        end
    end

    always_ff @(posedge core_clk or negedge rst_all_n) begin
        if (!rst_all_n) begin
            stream_channel_index_select_r <= '0;
            stream_byte_order_r           <= '0;
            order_stg_r                   <= '0;
            status_lamp_behaviour_r       <= LAMP_ACTIVE;
            persist_r                     <= 1'b0;
            bulk_r                        <= 1'b0;
            register_set_consistent_flag_r <= 1'b1;
            for (int i = 0; i < CHAN_N; i++) begin
                link_r[i]     <= '0;
                link_stg_r[i] <= '0;
                pkt_r[i]      <= PKT_RESET;
                pkt_stg_r[i]  <= PKT_RESET;
            end
        end else if (soft_rst_r) begin
            stream_channel_index_select_r <= '0;
            stream_byte_order_r           <= '0;
            order_stg_r                   <= '0;
            status_lamp_behaviour_r       <= LAMP_ACTIVE;
            persist_r                     <= 1'b0;
            bulk_r                        <= 1'b0;
            register_set_consistent_flag_r <= 1'b1;
            for (int i = 0; i < CHAN_N; i++) begin
                link_r[i]     <= '0;
                link_stg_r[i] <= '0;
                pkt_r[i]      <= PKT_RESET;
                pkt_stg_r[i]  <= PKT_RESET;
            end
        end else begin
            if (wr_sel) begin
                stream_channel_index_select_r <= reg_wdata[CHAN_W-1:0];
            end
            if (wr_lamp && lamp_mode_ok) begin
                status_lamp_behaviour_r <= lamp_mode_e'(reg_wdata[1:0]);
            end
            if (cmd_p_beg) begin
                persist_r <= 1'b1;
            end else if (cmd_p_end) begin
                persist_r <= 1'b0;
            end
            if (cmd_b_beg) begin
                bulk_r <= 1'b1;
            end else if (cmd_b_end) begin
                bulk_r <= 1'b0;
            end
            // Outside bulk mode a zero size is refused; inside it is staged unchecked
            if (wr_link) begin
                link_stg_r[stream_channel_index_select_r] <= reg_wdata[LINK_W-1:0];
            end
            if (wr_order) begin
                order_stg_r[stream_channel_index_select_r] <= reg_wdata[0];
            end
            if (wr_pkt && (pkt_ok || bulk_r)) begin
                pkt_stg_r[stream_channel_index_select_r] <= reg_wdata[PKT_W-1:0];
            end
            if (cmd_b_end) begin
                register_set_consistent_flag_r <= set_ok;
                if (set_ok) begin
                    stream_byte_order_r <= order_stg_r;
                    for (int i = 0; i < CHAN_N; i++) begin
                        link_r[i] <= link_stg_r[i];
                        pkt_r[i]  <= pkt_stg_r[i];
                    end
                end
            end else if (!bulk_r && register_set_consistent_flag_r) begin
                // A refused set stays staged only, never leaks live after finish
                stream_byte_order_r <= order_stg_r;
                for (int i = 0; i < CHAN_N; i++) begin
                    link_r[i] <= link_stg_r[i];
                    pkt_r[i]  <= pkt_stg_r[i];
                end
            end
        end
    end

    // Output registers and read data
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= '0;
            lamp_r  <= 1'b0;
            pix_r   <= '0;
        end else begin
            rdata_r <= reg_read ? rd_mux : '0;
            lamp_r  <= lamp_nxt;
            for (int i = 0; i < CHAN_N; i++) begin
                pix_r[i*16 +: 16] <= order_bytes(pixel_in[i*16 +: 16],
                                                 stream_byte_order_r[i]);
            end
        end
    end

    assign reg_rdata    = rdata_r;
    assign status_lamp  = lamp_r;
    assign pixel_out    = pix_r;
    assign device_restart = soft_rst_r;
    // Packet size is bytes to send for a transmitter, max accepted for a receiver
    for (genvar g = 0; g < CHAN_N; g++) begin : g_out
        assign stream_channel_link_index[g*LINK_W +: LINK_W] = link_r[g];
        assign stream_packet_bytes[g*PKT_W +: PKT_W]         = pkt_r[g];
    end

    lamp_off_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (status_lamp_behaviour_r == LAMP_OFF) [*2] |-> !status_lamp)
        else $error("lamp lit in off mode");
    lamp_err_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (status_lamp_behaviour_r == LAMP_ERROR_ONLY) |=> (status_lamp == $past(err_sync_r[1])))
        else $error("error-only lamp mismatch");
    persist_on_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (cmd_p_beg && !soft_rst_r) |=> persist_r)
        else $error("persistence not entered");
    persist_off_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (cmd_p_end && !cmd_p_beg && !soft_rst_r) |=> !persist_r)
        else $error("persistence not left");
    bulk_lock_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (!bulk_r && lock_s) |=> !bulk_r)
        else $error("bulk entered while locked");
    flag_update_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (cmd_b_end && !soft_rst_r) |=> (register_set_consistent_flag_r == $past(set_ok)))
        else $error("consistency flag not refreshed");
    bulk_hold_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (bulk_r && !cmd_b_end && !soft_rst_r) |=> $stable(stream_byte_order_r))
        else $error("bulk staging leaked early");
    read_timing_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (reg_read && sel_hit(reg_addr, OFF_EVT_TOTAL)) |=> (reg_rdata == {24'h0, EVT_TOTAL_VAL}))
        else $error("event count read wrong");
    legacy_count_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (reg_read && sel_hit(reg_addr, OFF_MSG_TOTAL)) |=> (reg_rdata == {24'h0, EVT_TOTAL_VAL}))
        else $error("legacy count differs");
    restart_clear_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        soft_rst_r |=> (!bulk_r && !persist_r && stream_channel_index_select_r == '0))
        else $error("restart left state");
endmodule : device_control_bank
`default_nettype wire

// >>> sim/host_model.sv
// Host side model: register bus master for the device control bank
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic        core_clk,
    input  wire logic        bulk_locked,
    output logic [7:0]       reg_addr,
    output logic [31:0]      reg_wdata,
    output logic             reg_write,
    output logic             reg_read,
    input  wire logic [31:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask : wr

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(posedge core_clk);
        v = reg_rdata;
    endtask : rd

    // Polite host: no bulk session while the begin command is locked
    task automatic bulk_go;
        if (!bulk_locked) begin
            wr(8'h28, 32'h0000_0004);
        end
    endtask : bulk_go

    // Device is unknown after restart, so probe it afresh
    task automatic rediscover(output logic [31:0] v);
        repeat (8) @(posedge core_clk);
        rd(8'h14, v);
    endtask : rediscover
endmodule : host_model
`default_nettype wire

// >>> sim/test_camera_device_control_features.sv
// Self-checking bench for the device control bank
`timescale 1ns/1ps
`default_nettype none
module test_camera_device_control_features;
    import devctl_pkg::*;
    logic        core_clk;
    logic        reset_n;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [31:0] reg_rdata;
    logic [3:0]  chan_is_receiver;
    logic        device_error;
    logic        status_lamp_raw;
    logic [63:0] pixel_in;
    logic        bulk_locked;
    logic [63:0] pixel_out;
    logic [15:0] link_idx;
    logic [63:0] pkt;
    logic        status_lamp;
    logic        restart_ack;
    logic        device_restart;
    logic [31:0] d;
    int          errors;
    int          n_compared;

    host_model host (.core_clk(core_clk), .bulk_locked(bulk_locked), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata));
    device_control_bank dut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .chan_is_receiver(chan_is_receiver),
        .device_error(device_error), .status_lamp_raw(status_lamp_raw),
        .pixel_in(pixel_in), .bulk_locked(bulk_locked), .pixel_out(pixel_out),
        .stream_channel_link_index(link_idx), .stream_packet_bytes(pkt),
        .status_lamp(status_lamp), .restart_ack(restart_ack),
        .device_restart(device_restart));

    initial core_clk = 1'b0;
    always #2 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: got %h want %h", $time, m, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    task automatic t_reset;
        check(pkt[31:0], {2{PKT_RESET}}, "pkt reset");
        check({16'h0000, link_idx}, 32'h0, "link reset");
        host.rd(OFF_EVT_TOTAL, d);
        check(d, {24'h00_0000, EVT_TOTAL_VAL}, "event total");
        host.rd(OFF_MSG_TOTAL, d);
        check(d, {24'h00_0000, EVT_TOTAL_VAL}, "legacy total");
        host.wr(OFF_TEXT_ENC, 32'h0);
        host.rd(OFF_TEXT_ENC, d);
        check(d, {31'h0, TEXT_ENC_ASCII}, "encoding");
        host.rd(8'h40, d);
        check(d, UNMAPPED_VAL, "unmapped");
        host.rd(OFF_LAMP_MODE, d);
        check(d, 32'h1, "lamp reset");
        $display("done: reset values");
    endtask : t_reset

    task automatic t_chan;
        logic [15:0] p;
        for (int c = 0; c < 4; c++) begin
            host.wr(OFF_CHAN_SEL, 32'(c));
            host.wr(OFF_CHAN_LINK, 32'(c + 3));
            host.wr(OFF_CHAN_PKT, 32'(c + 64));
            host.wr(OFF_CHAN_ORDER, 32'(c % 2));
            host.rd(OFF_CHAN_DIR, d);
            check(d, {31'h0, chan_is_receiver[c]}, "direction");
        end
        repeat (2) @(posedge core_clk);
        for (int c = 0; c < 4; c++) begin
            p = pixel_in[c*16 +: 16];
            check({28'h000_0000, link_idx[c*4 +: 4]}, 32'(c + 3), "live link");
            check({16'h0000, pkt[c*16 +: 16]}, 32'(c + 64), "live pkt");
            check({16'h0000, pixel_out[c*16 +: 16]},
                {16'h0000, (c % 2) ? {p[7:0], p[15:8]} : p}, "byte order");
        end
        // Zero is no legal size outside a bulk session
        host.wr(OFF_CHAN_PKT, 32'h0);
        host.rd(OFF_CHAN_PKT, d);
        check(d, 32'h43, "zero pkt");
        $display("done: channel settings");
    endtask : t_chan

    task automatic t_lamp;
        logic [1:0] m;
        for (int i = 0; i < 12; i++) begin
            m = 2'(i / 4);
            host.wr(OFF_LAMP_MODE, 32'(m));
            @(posedge core_clk);
            device_error <= i[0];
            status_lamp_raw <= i[1];
            repeat (5) @(posedge core_clk);
            check({31'h0, status_lamp}, {31'h0, (m == LAMP_ACTIVE) ? i[1] :
                (m == LAMP_ERROR_ONLY) ? i[0] : 1'b0}, "lamp");
        end
        host.wr(OFF_LAMP_MODE, 32'h3);
        host.rd(OFF_LAMP_MODE, d);
        check(d, 32'h2, "lamp mode 3");
        $display("done: lamps");
    endtask : t_lamp

    task automatic t_persist;
        logic [31:0] saved;
        host.wr(OFF_COMMAND, 32'h1);
        host.rd(OFF_STATUS, d);
        check({31'h0, d[ST_PERSIST]}, 32'h1, "persist on");
        host.rd(OFF_CHAN_PKT, saved);
        check(saved, 32'h43, "persist read");
        host.rd(OFF_COMMAND, d);
        check(d, 32'h0, "command reads");
        host.wr(OFF_COMMAND, 32'h2);
        host.rd(OFF_STATUS, d);
        check({31'h0, d[ST_PERSIST]}, 32'h0, "persist off");
        $display("done: persistence");
    endtask : t_persist

    task automatic t_bulk;
        @(posedge core_clk);
        bulk_locked <= 1'b1;
        repeat (3) @(posedge core_clk);
        // Host breaks the lock on purpose here
        host.wr(OFF_COMMAND, 32'h4);
        host.rd(OFF_STATUS, d);
        check({28'h000_0000, d[3:0]}, 32'h9, "locked begin");
        bulk_locked <= 1'b0;
        repeat (3) @(posedge core_clk);
        host.bulk_go();
        host.wr(OFF_CHAN_SEL, 32'h0);
        host.wr(OFF_CHAN_PKT, 32'h0);
        host.wr(OFF_CHAN_SEL, 32'h1);
        host.wr(OFF_CHAN_PKT, 32'hC8);
        repeat (2) @(posedge core_clk);
        check({16'h0000, pkt[31:16]}, 32'h41, "staged only");
        host.rd(OFF_STATUS, d);
        check({28'h000_0000, d[3:0]}, 32'h5, "bulk on");
        host.wr(OFF_COMMAND, 32'h8);
        host.rd(OFF_STATUS, d);
        check({31'h0, d[ST_CONSISTENT]}, 32'h0, "bad set");
        check({16'h0000, pkt[31:16]}, 32'h41, "bad not live");
        host.bulk_go();
        host.wr(OFF_CHAN_SEL, 32'h0);
        host.wr(OFF_CHAN_PKT, 32'h80);
        host.wr(OFF_COMMAND, 32'h8);
        host.wr(OFF_STATUS, 32'h0);
        host.rd(OFF_STATUS, d);
        check({28'h000_0000, d[3:0]}, 32'h1, "good set");
        check(pkt[31:0], 32'h00C8_0080, "set live");
        $display("done: bulk writes");
    endtask : t_bulk

    task automatic t_restart;
        int n;
        n = 0;
        host.wr(OFF_RESTART, 32'h2);
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            n += int'(restart_ack);
        end
        check(32'(n), 32'h0, "wrong key");
        host.wr(OFF_RESTART, RESTART_KEY);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (restart_ack !== 1'b1 && n < 20);
        check(32'(n), 32'h1, "ack delay");
        if (n >= 20) begin
            wrap_up();
        end
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (device_restart !== 1'b1 && n < 20);
        check(32'(n), 32'h5, "restart after ack");
        if (n >= 20) begin
            wrap_up();
        end
        host.rediscover(d);
        check(d, {24'h00_0000, EVT_TOTAL_VAL}, "rediscover");
        check({16'h0000, link_idx}, 32'h0, "link cleared");
        check(pkt[63:32], {2{PKT_RESET}}, "pkt cleared");
        host.rd(OFF_LAMP_MODE, d);
        check(d, 32'h1, "lamp cleared");
        $display("done: restart");
    endtask : t_restart

    initial begin
        reset_n = 1'b0;
        chan_is_receiver = 4'b1010;
        device_error = 1'b0;
        status_lamp_raw = 1'b0;
        pixel_in = 64'h1122_3344_5566_7788;
        bulk_locked = 1'b0;
        errors = 0;
        n_compared = 0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_reset();
        t_chan();
        t_lamp();
        t_persist();
        t_bulk();
        t_restart();
        wrap_up();
    end
endmodule : test_camera_device_control_features
`default_nettype wire
